// ===== src/iossp_top.sv
// Process image, mailbox object access and fault-output substitution of the I/O device.
`timescale 1ns/1ns
`include "iossp_regs.svh"
module iossp_top #(
    parameter int N_IN = 8,
    parameter int N_OUT = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bus state from the slave controller
    input wire logic [3:0] bus_state_report,
    // Mailbox object access request
    input wire logic mb_req,
    input wire logic mb_write,
    input wire logic [15:0] mb_index,
    input wire logic [7:0] mb_subindex,
    input wire logic [31:0] mb_wdata,
    // Mailbox object access answer
    output logic mb_ack,
    output logic [1:0] mb_result,
    output logic [31:0] mb_rdata,
    // Cyclic output image from the master
    input wire logic out_img_valid,
    input wire logic [7:0] output_process_map,
    // Cyclic input image to the master
    input wire logic in_img_read,
    output logic [7:0] input_process_map,
    output logic [31:0] status_process_map,
    // Field pins
    input wire logic [N_IN-1:0] din_pin,
    input wire logic [5:0] fault_pin,
    output logic [N_OUT-1:0] dout_pin,
    // Restart control
    input wire logic restart_req,
    output logic factory_restore_pulse
);
    logic [N_IN-1:0] din_s;
    logic [5:0] fault_s;
    logic [3:0] state_s;
    logic [7:0] mode_r;
    logic [7:0] pattern_r;
    logic [7:0] restore_r;
    logic [7:0] out_byte_r;
    logic [N_OUT-1:0] last_out_r;
    logic [N_OUT-1:0] dout_nxt;
    logic is_op;
    logic is_preop;
    iossp_pkg::iossp_mb_state_type mb_state_r;
    logic mb_write_r;
    logic [15:0] mb_index_r;
    logic [7:0] mb_sub_r;
    logic [31:0] mb_wdata_r;
    logic [31:0] rd_val;
    logic [1:0] rd_res;
    logic [1:0] wr_res;
    logic cyc_block;

    // Field inputs and fault lines come from outside the clock domain.
    iossp_sync2 #(.WIDTH(N_IN + 6)) u_sync_pins (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({fault_pin, din_pin}),
        .sync_out({fault_s, din_s})
    );

    // The bus state is registered once so every consumer sees a single value per cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_s <= `IOSSP_STATE_INIT;
        end else begin
            state_s <= bus_state_report;
        end
    end

    assign is_op = (state_s == `IOSSP_STATE_OP);
    assign is_preop = (state_s == `IOSSP_STATE_PREOP);

    // A cyclic image update is dropped while a mailbox message is executing.
    assign cyc_block = (mb_state_r == iossp_pkg::IOSSP_MB_EXEC);

    function automatic logic [31:0] map_entry(input logic [15:0] idx, input logic [7:0] sub);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (sub == `IOSSP_SUB_COUNT) begin
            v = {24'h00_0000, (idx == `IOSSP_IDX_STAT_MAP) ?
                `IOSSP_STAT_MAP_COUNT : `IOSSP_MAP_COUNT};
        end else begin
            unique case (idx)
                `IOSSP_IDX_OUT_MAP: v = `IOSSP_OUT_MAP_WORD;
                `IOSSP_IDX_IN_MAP: v = `IOSSP_IN_MAP_WORD;
                default: v = `IOSSP_STAT_MAP_WORD;
            endcase
        end
        return v;
    endfunction : map_entry

    // Latest output byte from the master; bits 7..4 are kept and read back through the output object but drive no pin.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_byte_r <= 8'h00;
        end else if (out_img_valid && !cyc_block) begin
            out_byte_r <= output_process_map;
        end
    end

    // Last value actually driven while operational, used by the hold mode.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_out_r <= '0;
        end else if (is_op) begin
            last_out_r <= out_byte_r[N_OUT-1:0];
        end
    end

    always_comb begin
        dout_nxt = out_byte_r[N_OUT-1:0];
        if (!is_op) begin
            unique case (mode_r)
                `IOSSP_MODE_HIGH: dout_nxt = '1;
                `IOSSP_MODE_HOLD: dout_nxt = last_out_r;
                `IOSSP_MODE_PATTERN: dout_nxt = pattern_r[N_OUT-1:0];
                default: dout_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_pin <= '0;
        end else begin
            dout_pin <= dout_nxt;
        end
    end

    // Input image and status word; the status word leaves the 26 bits above the six fault lines at zero.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_process_map <= 8'h00;
            status_process_map <= 32'h0000_0000;
        end else if (in_img_read && !cyc_block) begin
            input_process_map <= din_s;
            status_process_map <= {26'h000_0000, fault_s};
        end
    end

    // Mailbox read answers.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_res = `IOSSP_ACK_OK;
        unique case (mb_index_r)
            `IOSSP_IDX_OUT_MAP, `IOSSP_IDX_IN_MAP, `IOSSP_IDX_STAT_MAP:
                rd_val = map_entry(mb_index_r, mb_sub_r);
            `IOSSP_IDX_MODE: rd_val = {24'h00_0000, mode_r};
            `IOSSP_IDX_PATTERN:
                rd_val = (mb_sub_r == `IOSSP_SUB_COUNT) ? 32'h0000_0001 :
                    {24'h00_0000, pattern_r};
            `IOSSP_IDX_RESTORE: rd_val = {24'h00_0000, restore_r};
            `IOSSP_IDX_INPUT:
                rd_val = (mb_sub_r == `IOSSP_SUB_COUNT) ? {24'h00_0000, `IOSSP_OBJ_COUNT} :
                    {24'h00_0000, input_process_map};
            `IOSSP_IDX_STATUS:
                rd_val = (mb_sub_r == `IOSSP_SUB_COUNT) ?
                    {24'h00_0000, `IOSSP_STAT_OBJ_COUNT} : status_process_map;
            `IOSSP_IDX_OUTPUT:
                rd_val = (mb_sub_r == `IOSSP_SUB_COUNT) ? {24'h00_0000, `IOSSP_OBJ_COUNT} :
                    {24'h00_0000, out_byte_r};
            default: rd_res = `IOSSP_ACK_UNKNOWN;
        endcase
    end

    // Mailbox write verdicts: mode and pattern only in pre-operational, restore codes checked in any state.
    always_comb begin
        wr_res = `IOSSP_ACK_REFUSED;
        unique case (mb_index_r)
            `IOSSP_IDX_MODE:
                if (is_preop && mb_wdata_r[7:0] <= `IOSSP_MODE_PATTERN) begin
                    wr_res = `IOSSP_ACK_OK;
                end
            `IOSSP_IDX_PATTERN:
                if (is_preop && mb_sub_r == `IOSSP_SUB_VALUE) begin
                    wr_res = `IOSSP_ACK_OK;
                end
            `IOSSP_IDX_RESTORE:
                if (mb_wdata_r[7:0] <= `IOSSP_RESTORE_REQ) begin
                    wr_res = `IOSSP_ACK_OK;
                end
            `IOSSP_IDX_OUT_MAP, `IOSSP_IDX_IN_MAP, `IOSSP_IDX_STAT_MAP,
            `IOSSP_IDX_INPUT, `IOSSP_IDX_STATUS, `IOSSP_IDX_OUTPUT:
                wr_res = `IOSSP_ACK_REFUSED;
            default: wr_res = `IOSSP_ACK_UNKNOWN;
        endcase
    end

    // Mailbox sequencer: capture, execute for one cycle, answer; new requests wait.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mb_state_r <= iossp_pkg::IOSSP_MB_IDLE;
            mb_write_r <= 1'b0;
            mb_index_r <= 16'h0000;
            mb_sub_r <= 8'h00;
            mb_wdata_r <= 32'h0000_0000;
        end else begin
            unique case (mb_state_r)
                iossp_pkg::IOSSP_MB_IDLE:
                    if (mb_req) begin
                        mb_state_r <= iossp_pkg::IOSSP_MB_EXEC;
                        mb_write_r <= mb_write;
                        mb_index_r <= mb_index;
                        mb_sub_r <= mb_subindex;
                        mb_wdata_r <= mb_wdata;
                    end
                iossp_pkg::IOSSP_MB_EXEC: mb_state_r <= iossp_pkg::IOSSP_MB_DONE;
                iossp_pkg::IOSSP_MB_DONE: mb_state_r <= iossp_pkg::IOSSP_MB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mb_ack <= 1'b0;
            mb_result <= `IOSSP_ACK_OK;
            mb_rdata <= 32'h0000_0000;
        end else begin
            mb_ack <= (mb_state_r == iossp_pkg::IOSSP_MB_EXEC);
            if (mb_state_r == iossp_pkg::IOSSP_MB_EXEC) begin
                mb_result <= mb_write_r ? wr_res : rd_res;
                mb_rdata <= mb_write_r ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // Configuration objects; an accepted write lands in the execute cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= `IOSSP_MODE_RESET;
            pattern_r <= `IOSSP_PATTERN_RESET;
        end else if (mb_state_r == iossp_pkg::IOSSP_MB_EXEC && mb_write_r &&
                     wr_res == `IOSSP_ACK_OK) begin
            if (mb_index_r == `IOSSP_IDX_MODE) begin
                mode_r <= mb_wdata_r[7:0];
            end
            if (mb_index_r == `IOSSP_IDX_PATTERN) begin
                pattern_r <= {4'h0, mb_wdata_r[3:0]};
            end
        end
    end

    // The restore request only arms; it fires when the restart request comes.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            restore_r <= `IOSSP_RESTORE_NORMAL;
            factory_restore_pulse <= 1'b0;
        end else begin
            factory_restore_pulse <= restart_req && (restore_r == `IOSSP_RESTORE_REQ);
            // An accepted write that meets a restart wins, so it waits for the next restart.
            if (mb_state_r == iossp_pkg::IOSSP_MB_EXEC && mb_write_r &&
                mb_index_r == `IOSSP_IDX_RESTORE && wr_res == `IOSSP_ACK_OK) begin
                restore_r <= mb_wdata_r[7:0];
            end else if (restart_req) begin
                restore_r <= `IOSSP_RESTORE_NORMAL;
            end
        end
    end
endmodule : iossp_top

// ===== src/iossp_regs.svh
// Object indices, field layouts, reset values and codes of the process-image block.
`ifndef IOSSP_REGS_SVH
`define IOSSP_REGS_SVH

`define IOSSP_IDX_OUT_MAP 16'h1600
`define IOSSP_IDX_IN_MAP 16'h1a00
`define IOSSP_IDX_STAT_MAP 16'h1a01
`define IOSSP_IDX_MODE 16'h2100
`define IOSSP_IDX_PATTERN 16'h2102
`define IOSSP_IDX_RESTORE 16'h2f00
`define IOSSP_IDX_INPUT 16'h4000
`define IOSSP_IDX_STATUS 16'h4001
`define IOSSP_IDX_OUTPUT 16'h5000

`define IOSSP_SUB_COUNT 8'h00
`define IOSSP_SUB_VALUE 8'h01

`define IOSSP_OUT_MAP_WORD 32'h5000_0108
`define IOSSP_IN_MAP_WORD 32'h4000_0108
`define IOSSP_STAT_MAP_WORD 32'h4001_0120
`define IOSSP_MAP_COUNT 8'h02
`define IOSSP_STAT_MAP_COUNT 8'h01
`define IOSSP_OBJ_COUNT 8'h02
`define IOSSP_STAT_OBJ_COUNT 8'h01

`define IOSSP_MODE_LOW 8'h00
`define IOSSP_MODE_HIGH 8'h01
`define IOSSP_MODE_HOLD 8'h02
`define IOSSP_MODE_PATTERN 8'h03
`define IOSSP_MODE_RESET 8'h00
`define IOSSP_PATTERN_RESET 8'h00

`define IOSSP_RESTORE_NORMAL 8'h00
`define IOSSP_RESTORE_REQ 8'h01

`define IOSSP_STATE_INIT 4'h1
`define IOSSP_STATE_PREOP 4'h2
`define IOSSP_STATE_SAFEOP 4'h4
`define IOSSP_STATE_OP 4'h8

`define IOSSP_ACK_OK 2'h0
`define IOSSP_ACK_REFUSED 2'h1
`define IOSSP_ACK_UNKNOWN 2'h2

`endif

// ===== src/iossp_pkg.sv
// Types shared by the process-image block.
package iossp_pkg;
    typedef enum logic [1:0] {
        IOSSP_MB_IDLE,
        IOSSP_MB_EXEC,
        IOSSP_MB_DONE
    } iossp_mb_state_type;
endpackage : iossp_pkg

// ===== src/iossp_sync2.sv
// Two-stage synchroniser for a bundle of pin levels.
`timescale 1ns/1ns
`include "iossp_regs.svh"
module iossp_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : iossp_sync2

// ===== tb/iossp_asserts.sv
// Port-level checker of the process-image block.
`timescale 1ns/1ns
module iossp_asserts #(
    parameter int N_IN = 8,
    parameter int N_OUT = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Inputs of the block
    input wire logic [3:0] bus_state_report,
    input wire logic mb_req,
    input wire logic out_img_valid,
    input wire logic [7:0] output_process_map,
    input wire logic in_img_read,
    input wire logic [N_IN-1:0] din_pin,
    input wire logic [5:0] fault_pin,
    input wire logic restart_req,
    // Outputs of the block
    input wire logic mb_ack,
    input wire logic [1:0] mb_result,
    input wire logic [31:0] mb_rdata,
    input wire logic [7:0] input_process_map,
    input wire logic [31:0] status_process_map,
    input wire logic [N_OUT-1:0] dout_pin,
    input wire logic factory_restore_pulse
);
    wire logic op = (bus_state_report == 4'h8);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_ACK_TWO: assert property ($rose(mb_req) |-> !mb_ack ##1 !mb_ack ##1 mb_ack)
        else $error("mailbox answer not two cycles after request");
    AST_ACK_ONE: assert property (mb_ack |=> !mb_ack)
        else $error("mailbox answer longer than one cycle");
    AST_ANS_HELD: assert property (!mb_ack |-> $stable(mb_result) && $stable(mb_rdata))
        else $error("mailbox answer changed between answers");
    // A mailbox answer may land a new mode or pattern, so those cycles are left out.
    AST_SAFE_STEADY: assert property ((!op && !mb_ack)[*4] |-> $stable(dout_pin))
        else $error("outputs moved while substituted");
    AST_OP_FOLLOW: assert property (op[*3] ##0 (out_img_valid && !mb_req) |->
        ##2 dout_pin == $past(output_process_map[N_OUT-1:0], 2))
        else $error("outputs do not follow the output byte");
    AST_IN_SNAP: assert property (in_img_read && !mb_req && din_pin == $past(din_pin) &&
        din_pin == $past(din_pin, 2) |=> input_process_map == $past(din_pin))
        else $error("input image does not match the input pins");
    AST_STAT_SNAP: assert property (in_img_read && !mb_req && fault_pin == $past(fault_pin) &&
        fault_pin == $past(fault_pin, 2) |=> status_process_map == {26'h000_0000, $past(fault_pin)})
        else $error("status image does not match the fault lines");
    AST_RST_CAUSE: assert property (factory_restore_pulse |-> $past(restart_req))
        else $error("factory restore without a restart");
    AST_RST_ONE: assert property (factory_restore_pulse |=> !factory_restore_pulse)
        else $error("factory restore pulse too long");
endmodule : iossp_asserts

bind iossp_top iossp_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) u_iossp_asserts (
    .sys_clk, .rst_n, .bus_state_report, .mb_req, .out_img_valid, .output_process_map,
    .in_img_read, .din_pin, .fault_pin, .restart_req, .mb_ack, .mb_result, .mb_rdata,
    .input_process_map, .status_process_map, .dout_pin, .factory_restore_pulse
);

// ===== tb/iossp_master.sv
// Behavioural fieldbus master driving mailbox requests and output images.
`timescale 1ns/1ns
module iossp_master (
    // Clock
    input wire logic sys_clk,
    // Mailbox
    output logic mb_req,
    output logic mb_write,
    output logic [15:0] mb_index,
    output logic [7:0] mb_subindex,
    output logic [31:0] mb_wdata,
    input wire logic mb_ack,
    input wire logic [1:0] mb_result,
    input wire logic [31:0] mb_rdata,
    // Output image
    output logic out_img_valid,
    output logic [7:0] output_process_map
);
    initial begin
        mb_req = 1'b0;
        mb_write = 1'b0;
        mb_index = 16'h0000;
        mb_subindex = 8'h00;
        mb_wdata = 32'h0000_0000;
        out_img_valid = 1'b0;
        output_process_map = 8'h00;
    end

    // The request stays up until the answer is seen, since a busy sequencer only takes a request once back in idle.
    task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic [1:0] res, output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        mb_req <= 1'b1;
        mb_write <= w;
        mb_index <= idx;
        mb_subindex <= sub;
        mb_wdata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (mb_ack !== 1'b1 && n < 20);
        // A missing answer hands back unknowns, which the caller's compare counts as a mismatch.
        res = (mb_ack === 1'b1) ? mb_result : 'x;
        rd = (mb_ack === 1'b1) ? mb_rdata : 'x;
        mb_req <= 1'b0;
        mb_index <= ~idx;
        mb_wdata <= ~wd;
    endtask : access

    // Writes the shared output area without waiting for the device, after a chosen delay.
    task automatic send_out(input logic [7:0] b, input int gap);
        repeat (gap + 1) @(posedge sys_clk);
        out_img_valid <= 1'b1;
        output_process_map <= b;
        @(posedge sys_clk);
        out_img_valid <= 1'b0;
        output_process_map <= ~b;
    endtask : send_out
endmodule : iossp_master

// ===== tb/tb_top.sv
// Self-checking bench of the process-image block.
`timescale 1ns/1ns
module tb_top;
    logic sys_clk, rst_n, mb_req, mb_write, mb_ack, out_img_valid, in_img_read;
    logic restart_req, factory_restore_pulse;
    logic [1:0] mb_result;
    logic [3:0] bus_state_report, dout_pin;
    logic [5:0] fault_pin;
    logic [7:0] mb_subindex, output_process_map, input_process_map, din_pin;
    logic [15:0] mb_index;
    logic [31:0] mb_wdata, mb_rdata, status_process_map;
    int failures, checks;

    iossp_top DUT (
        .sys_clk, .rst_n, .bus_state_report, .mb_req, .mb_write, .mb_index, .mb_subindex,
        .mb_wdata, .mb_ack, .mb_result, .mb_rdata, .out_img_valid, .output_process_map,
        .in_img_read, .input_process_map, .status_process_map, .din_pin, .fault_pin,
        .dout_pin, .restart_req, .factory_restore_pulse
    );
    iossp_master u_master (
        .sys_clk, .mb_req, .mb_write, .mb_index, .mb_subindex, .mb_wdata, .mb_ack,
        .mb_result, .mb_rdata, .out_img_valid, .output_process_map
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic mbx(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic [1:0] eres, input logic [31:0] erd);
        logic [1:0] res;
        logic [31:0] rd;
        u_master.access(w, idx, sub, wd, res, rd);
        check({30'h0000_0000, res}, {30'h0000_0000, eres}, "mailbox result");
        check(rd, erd, "mailbox data");
    endtask : mbx

    task automatic set_state(input logic [3:0] s);
        @(posedge sys_clk);
        bus_state_report <= s;
        repeat (4) @(posedge sys_clk);
    endtask : set_state

    task automatic t_maps();
        mbx(1'b0, 16'h1600, 8'h01, 32'h0000_0000, 2'h0, 32'h5000_0108);
        mbx(1'b0, 16'h1a00, 8'h01, 32'h0000_0000, 2'h0, 32'h4000_0108);
        mbx(1'b0, 16'h1a01, 8'h01, 32'h0000_0000, 2'h0, 32'h4001_0120);
        mbx(1'b0, 16'h1a01, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0001);
        mbx(1'b1, 16'h1600, 8'h01, 32'h1234_5678, 2'h1, 32'h0000_0000);
        mbx(1'b0, 16'h2100, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0000);
        mbx(1'b0, 16'h2102, 8'h01, 32'h0000_0000, 2'h0, 32'h0000_0000);
        mbx(1'b1, 16'h2100, 8'h00, 32'h0000_0001, 2'h1, 32'h0000_0000);
        mbx(1'b1, 16'h3000, 8'h01, 32'h0000_0000, 2'h2, 32'h0000_0000);
        mbx(1'b0, 16'h3000, 8'h01, 32'h0000_0000, 2'h2, 32'h0000_0000);
        mbx(1'b0, 16'h1600, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0002);
        mbx(1'b0, 16'h4000, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0002);
        mbx(1'b0, 16'h5000, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0002);
        mbx(1'b0, 16'h2102, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0001);
        $display("t_maps done");
    endtask : t_maps

    task automatic t_inputs();
        @(posedge sys_clk);
        din_pin <= 8'h12;
        fault_pin <= 6'h25;
        repeat (4) @(posedge sys_clk);
        in_img_read <= 1'b1;
        @(posedge sys_clk);
        in_img_read <= 1'b0;
        @(posedge sys_clk);
        check({24'h00_0000, input_process_map}, 32'h0000_0012, "input image");
        check(status_process_map, 32'h0000_0025, "status image");
        mbx(1'b0, 16'h4001, 8'h01, 32'h0000_0000, 2'h0, 32'h0000_0025);
        $display("t_inputs done");
    endtask : t_inputs

    task automatic t_restore();
        mbx(1'b1, 16'h2f00, 8'h00, 32'h0000_0002, 2'h1, 32'h0000_0000);
        mbx(1'b1, 16'h2f00, 8'h00, 32'h0000_0001, 2'h0, 32'h0000_0000);
        mbx(1'b0, 16'h2f00, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0001);
        repeat (4) @(posedge sys_clk);
        check({31'h0000_0000, factory_restore_pulse}, 32'h0000_0000, "early restore");
        restart_req <= 1'b1;
        @(posedge sys_clk);
        restart_req <= 1'b0;
        @(posedge sys_clk);
        check({31'h0000_0000, factory_restore_pulse}, 32'h0000_0001, "restore pulse");
        mbx(1'b0, 16'h2f00, 8'h00, 32'h0000_0000, 2'h0, 32'h0000_0000);
        $display("t_restore done");
    endtask : t_restore

    // Op byte 5 and pattern A differ in every bit, so each mode shows distinctly.
    task automatic t_safe();
        logic [3:0] want [4] = '{4'h0, 4'hf, 4'h5, 4'ha};
        set_state(4'h2);
        mbx(1'b1, 16'h2102, 8'h01, 32'h0000_000a, 2'h0, 32'h0000_0000);
        mbx(1'b1, 16'h2100, 8'h00, 32'h0000_0004, 2'h1, 32'h0000_0000);
        mbx(1'b1, 16'h2102, 8'h00, 32'h0000_0005, 2'h1, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            set_state(4'h2);
            mbx(1'b1, 16'h2100, 8'h00, 32'(m), 2'h0, 32'h0000_0000);
            set_state(4'h8);
            u_master.send_out(8'hf5, m);
            repeat (4) @(posedge sys_clk);
            check({28'h000_0000, dout_pin}, 32'h0000_0005, "op outputs");
            mbx(1'b0, 16'h5000, 8'h01, 32'h0000_0000, 2'h0, 32'h0000_00f5);
            set_state(4'h4);
            check({28'h000_0000, dout_pin}, {28'h000_0000, want[m]}, "substitute");
            // A new byte differing from every substitute must not reach the pins.
            mbx(1'b1, 16'h2102, 8'h01, 32'h0000_0005, 2'h1, 32'h0000_0000);
            u_master.send_out(8'h03, 0);
            repeat (4) @(posedge sys_clk);
            check({28'h000_0000, dout_pin}, {28'h000_0000, want[m]}, "substitute held");
            mbx(1'b1, 16'h2100, 8'h00, 32'h0000_0000, 2'h1, 32'h0000_0000);
        end
        $display("t_safe done");
    endtask : t_safe

    task automatic report_and_stop();
        $display("checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        rst_n = 1'b0;
        bus_state_report = 4'h1;
        in_img_read = 1'b0;
        restart_req = 1'b0;
        din_pin = 8'h00;
        fault_pin = 6'h00;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_maps();
        t_inputs();
        t_restore();
        t_safe();
        report_and_stop();
    end

    // The tests need well under a thousand cycles; this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        report_and_stop();
    end
endmodule : tb_top
